// ### design/legacy_binary_command_parser.sv
/*
  Legacy binary command parser: takes seven-byte frames, applies settings,
  and sends a seven-byte reply after the programmed delay.
  Assumes a serial front end giving byte strobes and taking reply bytes.
*/
`timescale 1ns/100ps
`default_nettype none
module legacy_binary_command_parser #(
  parameter int unsigned MS_CYCLES = legacy_cmd_pkg::MS_CYCLES_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        legacy_protocol_select,
  input  wire logic        rx_valid,
  input  wire logic        rx_sof,
  input  wire logic [7:0]  rx_data,
  input  wire logic        tx_ready,
  input  wire logic [15:0] out_power,
  input  wire logic [15:0] burst_power,
  input  wire logic [15:0] burst_power_min,
  input  wire logic [15:0] burst_power_max,
  input  wire logic [7:0]  temperature,
  input  wire logic        temp_out_of_range,
  input  wire logic        synth_unlocked,
  input  wire logic [3:0]  power_class,
  input  wire logic        summary_alarm,
  input  wire logic [3:0]  sw_version,
  input  wire logic [3:0]  freq_band_id,
  input  wire logic [23:0] serial_bcd,
  input  wire logic        temp_shutdown_on,
  input  wire logic [7:0]  temp_min,
  input  wire logic [7:0]  temp_max,
  input  wire logic [7:0]  temp_write_count,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_enable,
  output logic             power_on_state,
  output logic             power_on_store,
  output logic [3:0]       unit_address,
  output logic [7:0]       reply_delay_code,
  output logic [15:0]      carrier_freq,
  output logic [15:0]      power_threshold,
  output logic [3:0]       gain_backoff,
  output logic             gain_adjust,
  output logic             temp_log_cmd,
  output logic [7:0]       temp_log_arg,
  output logic             cmd_error
);
  legacy_cmd_pkg::state_t      state_reg;
  legacy_cmd_pkg::reply_kind_t kind_reg;
  logic [7:0]  fb_reg [7];
  logic [2:0]  idx_reg;
  logic [2:0]  rx_pos;
  logic        rx_take;
  logic [7:0]  sum_reg;
  logic        eval_reg;
  logic        addr_hit;
  logic        sum_ok;
  logic        good;
  logic [2:0]  build_idx_reg;
  logic [7:0]  build_sum_reg;
  logic [7:0]  build_byte;
  logic [2:0]  send_idx_reg;
  logic [7:0]  rd_data;
  logic [8:0]  delay_ms_reg;
  logic [legacy_cmd_pkg::MS_CNT_W-1:0] ms_cnt_reg;
  logic [7:0]  cmd;
  logic [7:0]  d1;
  logic [7:0]  d2;
  logic        d1_in_range;
  logic        d2_in_range;

  assign cmd = fb_reg[legacy_cmd_pkg::IDX_CMD];
  assign d1  = fb_reg[legacy_cmd_pkg::IDX_D1];
  assign d2  = fb_reg[legacy_cmd_pkg::IDX_D2];
  assign d1_in_range = d1 >= legacy_cmd_pkg::FIELD_MIN &&
                       d1 <= legacy_cmd_pkg::FIELD_MAX;
  assign d2_in_range = d2 >= legacy_cmd_pkg::FIELD_MIN &&
                       d2 <= legacy_cmd_pkg::FIELD_MAX;

  // frames are ignored while a reply is pending; no queueing on purpose
  assign rx_take = rx_valid && legacy_protocol_select &&
                   state_reg == legacy_cmd_pkg::S_IDLE;
  assign rx_pos  = rx_sof ? legacy_cmd_pkg::IDX_ADDR : idx_reg;
  assign addr_hit = fb_reg[legacy_cmd_pkg::IDX_ADDR] == {4'h0, unit_address};
  assign sum_ok   = fb_reg[legacy_cmd_pkg::IDX_LAST] == sum_reg;
  assign good     = eval_reg && addr_hit && sum_ok;

  // frame byte slots, start of frame realigns the position
  for (genvar i = 0; i < 7; i++) begin : g_slot
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        fb_reg[i] <= 8'h00;
      end else if (rx_take && rx_pos == 3'(i)) begin
        fb_reg[i] <= rx_data;
      end
    end
  end

  // byte position, running sum of bytes one to six
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idx_reg  <= 3'h0;
      sum_reg  <= 8'h00;
      eval_reg <= 1'b0;
    end else begin
      eval_reg <= rx_take && rx_pos == legacy_cmd_pkg::IDX_LAST;
      if (rx_take) begin
        idx_reg <= (rx_pos == legacy_cmd_pkg::IDX_LAST) ? 3'h0 : rx_pos + 3'h1;
        if (rx_pos == legacy_cmd_pkg::IDX_ADDR) begin
          sum_reg <= rx_data;
        end else if (rx_pos != legacy_cmd_pkg::IDX_LAST) begin
          sum_reg <= sum_reg + rx_data;
        end
      end
    end
  end

  // settings applied from an accepted, checked frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_enable        <= 1'b0;
      power_on_state   <= 1'b0;
      power_on_store   <= 1'b0;
      unit_address     <= legacy_cmd_pkg::RESET_ADDR;
      reply_delay_code <= legacy_cmd_pkg::RESET_DELAY;
      carrier_freq     <= 16'h0000;
      power_threshold  <= 16'h0000;
      gain_backoff     <= 4'h0;
      gain_adjust      <= 1'b0;
      temp_log_cmd     <= 1'b0;
      temp_log_arg     <= 8'h00;
    end else begin
      power_on_store <= 1'b0;
      gain_adjust    <= 1'b0;
      temp_log_cmd   <= 1'b0;
      if (good) begin
        case (cmd)
          legacy_cmd_pkg::CMD_TXCTL: begin
            if (d1 == legacy_cmd_pkg::TXC_OFF) begin
              tx_enable <= 1'b0;
            end else if (d1 == legacy_cmd_pkg::TXC_ON) begin
              tx_enable <= 1'b1;
            end else if (d1 == legacy_cmd_pkg::TXC_STORE_OFF ||
                         d1 == legacy_cmd_pkg::TXC_STORE_ON) begin
              power_on_state <= d1 == legacy_cmd_pkg::TXC_STORE_ON;
              power_on_store <= 1'b1;
            end
          end
          legacy_cmd_pkg::CMD_ADDR: begin
            if (d1_in_range) begin
              unit_address <= d1[3:0];
            end
            if (d2 != legacy_cmd_pkg::DELAY_KEEP) begin
              reply_delay_code <= d2;
            end
          end
          legacy_cmd_pkg::CMD_FREQ: carrier_freq <= {d1, d2};
          legacy_cmd_pkg::CMD_THRESH: power_threshold <= {d1, d2};
          legacy_cmd_pkg::CMD_GAIN: begin
            if (d2_in_range) begin
              gain_backoff <= d2[3:0];
              gain_adjust  <= 1'b1;
            end
          end
          legacy_cmd_pkg::CMD_TEMP: begin
            temp_log_cmd <= 1'b1;
            temp_log_arg <= d1;
          end
          default: ;
        endcase
      end
    end
  end

  // command error flag: set by a bad checksum or an unusable command
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_error <= 1'b0;
    end else if (eval_reg && addr_hit) begin
      if (!sum_ok) begin
        cmd_error <= 1'b1;
      end else begin
        case (cmd)
          legacy_cmd_pkg::CMD_STATUS, legacy_cmd_pkg::CMD_ADDR,
          legacy_cmd_pkg::CMD_FREQ, legacy_cmd_pkg::CMD_THRESH,
          legacy_cmd_pkg::CMD_TEMP: cmd_error <= 1'b0;
          legacy_cmd_pkg::CMD_TXCTL:
            cmd_error <= d1 > legacy_cmd_pkg::TXC_STORE_ON;
          legacy_cmd_pkg::CMD_BURST:
            cmd_error <= d1 > legacy_cmd_pkg::SEL_MINMAX;
          legacy_cmd_pkg::CMD_DEVID:
            cmd_error <= d1 != legacy_cmd_pkg::SEL_CURRENT;
          legacy_cmd_pkg::CMD_GAIN: cmd_error <= !d2_in_range;
          default: cmd_error <= 1'b1;
        endcase
      end
    end
  end

  // reply format picked from the command
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      kind_reg <= legacy_cmd_pkg::RK_STATUS;
    end else if (eval_reg) begin
      kind_reg <= legacy_cmd_pkg::RK_STATUS;
      if (sum_ok) begin
        case (cmd)
          legacy_cmd_pkg::CMD_THRESH: kind_reg <= legacy_cmd_pkg::RK_THRESH;
          legacy_cmd_pkg::CMD_BURST: begin
            if (d1 == legacy_cmd_pkg::SEL_CURRENT) begin
              kind_reg <= legacy_cmd_pkg::RK_BURST;
            end else if (d1 == legacy_cmd_pkg::SEL_MINMAX) begin
              kind_reg <= legacy_cmd_pkg::RK_MINMAX;
            end
          end
          legacy_cmd_pkg::CMD_DEVID: begin
            if (d1 == legacy_cmd_pkg::SEL_CURRENT) begin
              kind_reg <= legacy_cmd_pkg::RK_DEVID;
            end
          end
          legacy_cmd_pkg::CMD_TEMP: kind_reg <= legacy_cmd_pkg::RK_TEMP;
          default: kind_reg <= legacy_cmd_pkg::RK_STATUS;
        endcase
      end
    end
  end

  // reply byte under construction, checksum last
  always_comb begin
    build_byte = 8'h00;
    if (build_idx_reg == legacy_cmd_pkg::IDX_ADDR) begin
      build_byte = {unit_address, 4'h0};
    end else if (build_idx_reg == legacy_cmd_pkg::IDX_LAST) begin
      build_byte = build_sum_reg;
    end else begin
      case (kind_reg)
        legacy_cmd_pkg::RK_THRESH, legacy_cmd_pkg::RK_BURST: begin
          case (build_idx_reg)
            3'h1: build_byte = burst_power[15:8];
            3'h2: build_byte = burst_power[7:0];
            3'h3: build_byte = power_threshold[15:8];
            3'h4: build_byte = power_threshold[7:0];
            default: build_byte = {4'h0,
              (kind_reg == legacy_cmd_pkg::RK_THRESH) ?
              legacy_cmd_pkg::TAG_THRESH : legacy_cmd_pkg::TAG_BURST};
          endcase
        end
        legacy_cmd_pkg::RK_MINMAX: begin
          case (build_idx_reg)
            3'h1: build_byte = burst_power_max[15:8];
            3'h2: build_byte = burst_power_max[7:0];
            3'h3: build_byte = burst_power_min[15:8];
            3'h4: build_byte = burst_power_min[7:0];
            default: build_byte = {4'h0, legacy_cmd_pkg::TAG_MINMAX};
          endcase
        end
        legacy_cmd_pkg::RK_DEVID: begin
          case (build_idx_reg)
            3'h1: build_byte = {freq_band_id, legacy_cmd_pkg::MAKER_ID};
            3'h2: build_byte = serial_bcd[23:16];
            3'h3: build_byte = serial_bcd[15:8];
            3'h4: build_byte = serial_bcd[7:0];
            default: build_byte = {4'h0, legacy_cmd_pkg::TAG_MINMAX};
          endcase
        end
        legacy_cmd_pkg::RK_TEMP: begin
          case (build_idx_reg)
            3'h1: build_byte = {7'h00, temp_shutdown_on};
            3'h2: build_byte = temp_min;
            3'h3: build_byte = temp_max;
            3'h4: build_byte = temp_write_count;
            default: build_byte = 8'h00;
          endcase
        end
        default: begin
          case (build_idx_reg)
            3'h1: build_byte = out_power[15:8];
            3'h2: build_byte = out_power[7:0];
            3'h3: build_byte = temperature;
            3'h4: build_byte = {power_class, tx_enable, cmd_error,
                                synth_unlocked, temp_out_of_range};
            default: build_byte = {sw_version, summary_alarm ?
              legacy_cmd_pkg::ALARM_ON : legacy_cmd_pkg::ALARM_OFF};
          endcase
        end
      endcase
    end
  end

  reply_frame_mem u_mem (
    .mclk    (mclk),
    .wr_en   (state_reg == legacy_cmd_pkg::S_BUILD),
    .wr_addr (build_idx_reg),
    .wr_data (build_byte),
    .rd_addr (send_idx_reg),
    .rd_data (rd_data)
  );

  // reply delay, runs in parallel with the frame build
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      delay_ms_reg <= 9'h000;
      ms_cnt_reg   <= '0;
    end else if (good || (eval_reg && addr_hit)) begin
      ms_cnt_reg <= '0;
      if (reply_delay_code == legacy_cmd_pkg::DELAY_ZERO ||
          reply_delay_code == legacy_cmd_pkg::DELAY_FULL) begin
        delay_ms_reg <= legacy_cmd_pkg::DELAY_LONG_MS;
      end else begin
        delay_ms_reg <= {1'b0, reply_delay_code};
      end
    end else if (delay_ms_reg != 9'h000) begin
      if (ms_cnt_reg == legacy_cmd_pkg::MS_CNT_W'(MS_CYCLES - 1)) begin
        ms_cnt_reg   <= '0;
        delay_ms_reg <= delay_ms_reg - 9'h001;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 1'b1;
      end
    end
  end

  // sequencing: build, wait, then hand bytes out one by one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= legacy_cmd_pkg::S_IDLE;
      build_idx_reg <= 3'h0;
      build_sum_reg <= 8'h00;
      send_idx_reg  <= 3'h0;
      tx_valid      <= 1'b0;
      tx_data       <= 8'h00;
    end else begin
      case (state_reg)
        legacy_cmd_pkg::S_IDLE: begin
          build_idx_reg <= 3'h0;
          build_sum_reg <= 8'h00;
          if (eval_reg && addr_hit) begin
            state_reg <= legacy_cmd_pkg::S_BUILD;
          end
        end
        legacy_cmd_pkg::S_BUILD: begin
          build_sum_reg <= build_sum_reg + build_byte;
          build_idx_reg <= build_idx_reg + 3'h1;
          if (build_idx_reg == legacy_cmd_pkg::IDX_LAST) begin
            state_reg <= legacy_cmd_pkg::S_WAIT;
          end
        end
        legacy_cmd_pkg::S_WAIT: begin
          send_idx_reg <= 3'h0;
          if (delay_ms_reg == 9'h000) begin
            state_reg <= legacy_cmd_pkg::S_FETCH;
          end
        end
        legacy_cmd_pkg::S_FETCH: state_reg <= legacy_cmd_pkg::S_LATCH;
        legacy_cmd_pkg::S_LATCH: begin
          tx_data   <= rd_data;
          tx_valid  <= 1'b1;
          state_reg <= legacy_cmd_pkg::S_SHOW;
        end
        legacy_cmd_pkg::S_SHOW: begin
          if (tx_ready) begin
            tx_valid     <= 1'b0;
            send_idx_reg <= send_idx_reg + 3'h1;
            state_reg    <= (send_idx_reg == legacy_cmd_pkg::IDX_LAST) ?
                            legacy_cmd_pkg::S_IDLE : legacy_cmd_pkg::S_FETCH;
          end
        end
        default: state_reg <= legacy_cmd_pkg::S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_proto_gate_idle: assert property (
    state_reg == legacy_cmd_pkg::S_IDLE && !legacy_protocol_select
    |=> !eval_reg) else $error("frame taken with protocol deselected");
  a_bad_sum_flags: assert property (
    eval_reg && addr_hit && !sum_ok |=> cmd_error ##1 cmd_error)
    else $error("bad checksum did not flag command error");
  a_foreign_dropped: assert property (
    eval_reg && !addr_hit |=> state_reg == legacy_cmd_pkg::S_IDLE [*2])
    else $error("frame for another address was answered");
  a_tx_on_set: assert property (
    good && cmd == legacy_cmd_pkg::CMD_TXCTL && d1 == legacy_cmd_pkg::TXC_ON
    |=> tx_enable) else $error("transmit on not applied");
  a_addr_adopted: assert property (
    good && cmd == legacy_cmd_pkg::CMD_ADDR && d1_in_range
    |=> unit_address == $past(d1[3:0])) else $error("address not adopted");
  a_delay_kept: assert property (
    good && cmd == legacy_cmd_pkg::CMD_ADDR && d2 == legacy_cmd_pkg::DELAY_KEEP
    |=> $stable(reply_delay_code)) else $error("delay code 0xaa changed delay");
  a_freq_pairing: assert property (
    good && cmd == legacy_cmd_pkg::CMD_FREQ
    |=> carrier_freq[15:8] == $past(d1) && carrier_freq[7:0] == $past(d2))
    else $error("carrier frequency bytes misordered");
  a_long_delay: assert property (
    eval_reg && addr_hit && (reply_delay_code == legacy_cmd_pkg::DELAY_ZERO ||
    reply_delay_code == legacy_cmd_pkg::DELAY_FULL)
    |=> delay_ms_reg == legacy_cmd_pkg::DELAY_LONG_MS)
    else $error("long delay code not 256 ms");
  a_reply_address: assert property (
    tx_valid && send_idx_reg == legacy_cmd_pkg::IDX_ADDR
    |-> tx_data == {unit_address, 4'h0}) else $error("reply address wrong");
  a_no_early_reply: assert property (
    $rose(tx_valid) && send_idx_reg == legacy_cmd_pkg::IDX_ADDR
    |-> delay_ms_reg == 9'h000) else $error("reply sent before delay");
endmodule
`default_nettype wire

// ### common/legacy_cmd_pkg.sv
/*
  Constants, encodings and state types for the legacy binary command parser.
  Assumes a 125 MHz system clock and byte strobes from a serial front end.
*/
package legacy_cmd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_CNT_W      = 17;

  localparam logic [2:0] IDX_ADDR  = 3'h0;
  localparam logic [2:0] IDX_CMD   = 3'h1;
  localparam logic [2:0] IDX_D1    = 3'h2;
  localparam logic [2:0] IDX_D2    = 3'h3;
  localparam logic [2:0] IDX_B6    = 3'h5;
  localparam logic [2:0] IDX_LAST  = 3'h6;

  localparam logic [7:0] CMD_STATUS = 8'h01;
  localparam logic [7:0] CMD_TXCTL  = 8'h02;
  localparam logic [7:0] CMD_ADDR   = 8'h03;
  localparam logic [7:0] CMD_FREQ   = 8'h04;
  localparam logic [7:0] CMD_THRESH = 8'h05;
  localparam logic [7:0] CMD_BURST  = 8'h06;
  localparam logic [7:0] CMD_DEVID  = 8'h07;
  localparam logic [7:0] CMD_TEMP   = 8'h09;
  localparam logic [7:0] CMD_GAIN   = 8'hff;

  localparam logic [7:0] TXC_OFF      = 8'h00;
  localparam logic [7:0] TXC_ON       = 8'h01;
  localparam logic [7:0] TXC_STORE_OFF = 8'h02;
  localparam logic [7:0] TXC_STORE_ON = 8'h03;
  localparam logic [7:0] SEL_CURRENT  = 8'h00;
  localparam logic [7:0] SEL_MINMAX   = 8'h01;

  localparam logic [7:0] FIELD_MIN    = 8'h01;
  localparam logic [7:0] FIELD_MAX    = 8'h0f;
  localparam logic [7:0] DELAY_KEEP   = 8'haa;
  localparam logic [7:0] DELAY_ZERO   = 8'h00;
  localparam logic [7:0] DELAY_FULL   = 8'hff;
  localparam logic [8:0] DELAY_LONG_MS = 9'h100;

  localparam logic [3:0] RESET_ADDR   = 4'h1;
  localparam logic [7:0] RESET_DELAY  = 8'h01;
  localparam logic [3:0] MAKER_ID     = 4'h5; // arbitrary value

  localparam logic [3:0] TAG_THRESH   = 4'hb;
  localparam logic [3:0] TAG_BURST    = 4'hc;
  localparam logic [3:0] TAG_MINMAX   = 4'hd;
  localparam logic [3:0] ALARM_ON     = 4'h9;
  localparam logic [3:0] ALARM_OFF    = 4'ha;

  typedef enum logic [2:0] {
    S_IDLE, S_BUILD, S_WAIT, S_FETCH, S_LATCH, S_SHOW
  } state_t;

  typedef enum logic [2:0] {
    RK_STATUS, RK_THRESH, RK_BURST, RK_MINMAX, RK_DEVID, RK_TEMP
  } reply_kind_t;
endpackage

// ### design/reply_frame_mem.sv
/*
  Eight-entry byte store holding one reply frame.
  Assumes one writer and one reader in the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module reply_frame_mem (
  input  wire logic       mclk,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [2:0] rd_addr,
  output logic      [7:0] rd_data
);
  logic [7:0] mem_reg [8];

  // plain storage, no reset needed: always written before being read
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // registered read, one cycle latency
  always_ff @(posedge mclk) begin
    rd_data <= mem_reg[rd_addr];
  end
endmodule
`default_nettype wire

// ### verification/reply_sink.sv
/*
  Partner model: serial front end that takes reply bytes.
  Assumes tx_valid and tx_data hold until taken; slow stalls ready.
*/
`timescale 1ns/100ps
`default_nettype none
module reply_sink (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic [7:0]      rep [7],
  output int              n_rx
);
  logic [1:0] ph_reg;
  // phase counter, lets ready come one cycle in four when stalling
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ph_reg <= 2'h0;
    else ph_reg <= ph_reg + 2'h1;
  end
  assign tx_ready = !slow || ph_reg == 2'h3;
  // keep each byte taken, in arrival order
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) n_rx <= 0;
    else if (tx_valid && tx_ready) begin
      rep[n_rx % 7] <= tx_data;
      n_rx <= n_rx + 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_legacy_binary_command_parser.sv
/*
  Testbench for the command parser: sends frames, judges replies.
  Assumes reply_sink as the serial front end, 1 ms shrunk to 10 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module test_legacy_binary_command_parser;
  localparam int MS = 10;
  logic mclk, rstn, sel, rx_valid, rx_sof, slow, tx_valid, tx_ready;
  logic tx_enable, power_on_state, power_on_store, gain_adjust;
  logic temp_log_cmd, cmd_error;
  logic [7:0] rx_data, tx_data, reply_delay_code, temp_log_arg;
  logic [3:0] unit_address, gain_backoff;
  logic [15:0] carrier_freq, power_threshold, pw;
  logic [7:0] rep [7];
  int n_rx, n_fail, check_count;
  int n_store, n_gain, n_tlog;

  legacy_binary_command_parser #(.MS_CYCLES(MS)) uut (
    .mclk, .rstn, .legacy_protocol_select(sel), .rx_valid, .rx_sof,
    .rx_data, .tx_ready, .out_power(pw), .burst_power(~pw),
    .burst_power_min(pw ^ 16'h00ff), .burst_power_max(pw ^ 16'hff00),
    .temperature(pw[7:0]), .temp_out_of_range(pw[0]),
    .synth_unlocked(pw[1]), .power_class(pw[11:8]),
    .summary_alarm(pw[2]), .sw_version(pw[15:12]),
    .freq_band_id(pw[7:4]), .serial_bcd({pw, pw[7:0]}),
    .temp_shutdown_on(pw[3]), .temp_min(pw[15:8]), .temp_max(pw[7:0]),
    .temp_write_count(pw[11:4]), .tx_valid, .tx_data, .tx_enable,
    .power_on_state, .power_on_store, .unit_address, .reply_delay_code,
    .carrier_freq, .power_threshold, .gain_backoff, .gain_adjust,
    .temp_log_cmd, .temp_log_arg, .cmd_error);
  reply_sink sink (.mclk, .rstn, .slow, .tx_valid, .tx_data, .tx_ready,
    .rep, .n_rx);

  // one-cycle strobes counted per cycle high, so a stuck strobe shows up
  always @(posedge mclk) begin
    n_store += power_on_store;
    n_gain  += gain_adjust;
    n_tlog  += temp_log_cmd;
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // one frame out, then the reply (or its absence) in; want is ms delay
  task automatic xfer(logic [7:0] a, c, d1, d2, logic bad, int want,
                      logic [3:0] ea);
    logic [7:0] f [7];
    int n0, lat;
    f = '{a, c, d1, d2, 8'haa, 8'haa, 8'h00};
    for (int i = 0; i < 6; i++) f[6] += f[i];
    if (bad) f[6]++;
    n0 = n_rx;
    for (int i = 0; i < 7; i++) begin
      rx_valid = 1'b1;
      rx_sof = i == 0;
      rx_data = f[i];
      @(posedge mclk) #1;
    end
    rx_valid = 1'b0;
    lat = 1;
    // no reply wanted: sit out the whole window so a stray one is caught
    while ((want == 0 || tx_valid !== 1'b1) &&
           lat < (want ? want * MS + 9 : 60)) begin
      @(posedge mclk) #1;
      lat++;
    end
    // a few cycles of slack, the far side tolerates late replies
    if (want) chk("delay ok", 1, lat >= want * MS && lat <= want * MS + 8);
    for (int i = 0; i < 200 && n_rx < n0 + (want ? 7 : 0); i++)
      @(posedge mclk) #1;
    chk("reply bytes", want ? 7 : 0, n_rx - n0);
    if (want) begin
      chk("reply address", {ea, 4'h0}, rep[0]);
      chk("reply sum", 8'(rep[0] + rep[1] + rep[2] + rep[3] + rep[4] +
          rep[5]), rep[6]);
    end
    repeat (2) @(posedge mclk) #1;
  endtask

  task automatic t_status();
    xfer(8'h01, 8'h01, 8'haa, 8'haa, 0, 1, 4'h1);
    chk("power hi", pw[15:8], rep[1]);
    chk("power lo", pw[7:0], rep[2]);
    chk("temperature", pw[7:0], rep[3]);
    chk("status 1", {pw[11:8], 2'h0, pw[1:0]}, rep[4]);
    chk("status 2", {pw[15:12], pw[2] ? 4'h9 : 4'ha}, rep[5]);
    $display("status done");
  endtask

  task automatic t_txctl();
    for (int i = 0; i < 4; i++) begin
      xfer(8'h01, 8'h02, 8'(i), 8'haa, 0, 1, 4'h1);
      chk("tx enable", i > 0, tx_enable);
      chk("power-up state", i == 3, power_on_state);
    end
    chk("store pulses", 2, n_store);
    $display("tx control done");
  endtask

  task automatic t_settings();
    slow = 1'b1;
    xfer(8'h01, 8'h04, 8'h12, 8'h34, 0, 1, 4'h1);
    chk("carrier", 16'h1234, carrier_freq);
    xfer(8'h01, 8'h05, 8'h0f, 8'ha0, 0, 1, 4'h1);
    chk("threshold", 16'h0fa0, power_threshold);
    chk("thresh reply", 16'h0fa0, {rep[3], rep[4]});
    chk("thresh tag", 8'h0b, rep[5]);
    // rated power taken as 40.00 dBm; continuous mode sits at 19.90 dBm
    xfer(8'h01, 8'h05, 8'h07, 8'hc6, 0, 1, 4'h1);
    chk("csm threshold", 16'h07c6, power_threshold);
    xfer(8'h01, 8'hff, 8'haa, 8'h0f, 0, 1, 4'h1);
    chk("backoff", 4'hf, gain_backoff);
    chk("gain pulse", 1, n_gain);
    xfer(8'h01, 8'h06, 8'h00, 8'haa, 0, 1, 4'h1);
    chk("burst", ~pw, {rep[1], rep[2]});
    chk("burst tag", 8'h0c, rep[5]);
    xfer(8'h01, 8'h06, 8'h01, 8'haa, 0, 1, 4'h1);
    chk("burst max", {pw[15:8] ^ 8'hff, 8'h0d}, {rep[1], rep[5]});
    xfer(8'h01, 8'h07, 8'h00, 8'haa, 0, 1, 4'h1);
    chk("device id", {pw[15:8], 8'h0d}, {rep[2], rep[5]});
    xfer(8'h01, 8'h09, 8'h5a, 8'haa, 0, 1, 4'h1);
    chk("temp log", {8'h5a, 7'h0, pw[3]}, {temp_log_arg, rep[1]});
    chk("temp log pulse", 1, n_tlog);
    slow = 1'b0;
    $display("settings done");
  endtask

  task automatic t_errors();
    xfer(8'h01, 8'h01, 8'haa, 8'haa, 1, 1, 4'h1);
    chk("sum error", 1, cmd_error);
    chk("error bit", 1, rep[4][2]);
    xfer(8'h01, 8'h01, 8'haa, 8'haa, 0, 1, 4'h1);
    chk("error clear", 0, cmd_error);
    xfer(8'h02, 8'h04, 8'h00, 8'h00, 0, 0, 4'h1);
    sel = 1'b0;
    xfer(8'h01, 8'h04, 8'h00, 8'h00, 0, 0, 4'h1);
    sel = 1'b1;
    chk("ignored", 16'h1234, carrier_freq);
    $display("errors done");
  endtask

  task automatic t_delay();
    xfer(8'h01, 8'h03, 8'h0f, 8'h03, 0, 1, 4'hf);
    chk("address", 4'hf, unit_address);
    xfer(8'h0f, 8'h03, 8'haa, 8'haa, 0, 3, 4'hf);
    chk("delay kept", 8'h03, reply_delay_code);
    xfer(8'h0f, 8'h03, 8'h0f, 8'h00, 0, 3, 4'hf);
    xfer(8'h0f, 8'h03, 8'h0f, 8'hff, 0, 256, 4'hf);
    xfer(8'h0f, 8'h01, 8'haa, 8'haa, 0, 256, 4'hf);
    $display("delay done");
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // watchdog, well past the roughly 6300 cycles the tests need
  initial begin
    #(8 * 40000);
    n_fail++;
    print_verdict();
  end
  initial begin
    {rstn, rx_valid, rx_sof, rx_data, slow} = '0;
    sel = 1'b1;
    pw = 16'h5c3b;
    repeat (10) @(posedge mclk);
    #1 rstn = 1'b1;
    t_status();
    t_txctl();
    t_settings();
    t_errors();
    t_delay();
    print_verdict();
  end
endmodule
`default_nettype wire
